// ==== core/fast_out_top.sv ====
// two fast outputs: mode select, counter compare actions, pwm channels
`default_nettype none

module fast_out_top #(
	parameter logic [31:0] CLK_RATE = fast_out_pkg::CLK_HZ
) (
	input  wire logic                           clk_i,
	input  wire logic                           rstn_i,
	input  wire fast_out_pkg::mode_t [1:0]      out_mode_i,
	input  wire logic [1:0]                     discrete_i,
	input  wire logic [1:0]                     step_drive_i,
	input  wire logic [1:0]                     pwm_enable_i,
	input  wire logic [1:0][31:0]               pwm_duty_i,
	input  wire logic [1:0][31:0]               pwm_freq_i,
	input  wire logic                           stop_mode_i,
	input  wire logic [1:0]                     stop_hold_i,
	input  wire logic [1:0][31:0]               stop_duty_i,
	input  wire logic [1:0][31:0]               stop_freq_i,
	input  wire logic [31:0]                    counter_one_accumulator_i,
	input  wire logic [31:0]                    counter_two_accumulator_i,
	input  wire logic [1:0]                     acc_update_i,
	input  wire logic [31:0]                    counter_one_compare_a_i,
	input  wire logic [31:0]                    counter_one_compare_b_i,
	input  wire logic [31:0]                    counter_two_compare_a_i,
	input  wire logic [31:0]                    counter_two_compare_b_i,
	input  wire fast_out_pkg::act_t [1:0][1:0]  match_action_i,
	output logic                                fast_output_a_o,
	output logic                                fast_output_b_o,
	output logic [1:0]                          match_state_o,
	output logic [1:0]                          match_hit_o,
	output logic [1:0]                          pwm_ready_o
);
	import fast_out_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic act_apply(input act_t act, input logic cur);
		case (act)
			ACT_ON:     act_apply = 1'b1;
			ACT_OFF:    act_apply = 1'b0;
			ACT_TOGGLE: act_apply = ~cur;
			default:    act_apply = cur;
		endcase
	endfunction : act_apply

	function automatic logic out_pick(input mode_t mode, input logic disc,
	                                  input logic pwm, input logic match,
	                                  input logic step);
		case (mode)
			MODE_NORMAL: out_pick = disc;
			MODE_PWM:    out_pick = pwm;
			MODE_MATCH:  out_pick = match;
			MODE_STEP:   out_pick = step;
			default:     out_pick = OUT_RST;
		endcase
	endfunction : out_pick

	// ----------------------------------------------------------------
	// per channel wiring
	// ----------------------------------------------------------------
	logic [1:0][31:0] acc_w;
	logic [1:0][31:0] cmp_a_w;
	logic [1:0][31:0] cmp_b_w;
	logic [1:0]       hit_a_w;
	logic [1:0]       hit_b_w;
	logic [1:0]       wave_w;
	logic [1:0]       armed_w;
	logic [1:0]       match_r;
	logic [1:0]       match_nxt;
	logic [1:0]       hit_r;
	logic [1:0]       hit_nxt;
	logic [1:0]       out_r;
	logic [1:0]       out_nxt;

	assign acc_w   = {counter_two_accumulator_i, counter_one_accumulator_i};
	assign cmp_a_w = {counter_two_compare_a_i, counter_one_compare_a_i};
	assign cmp_b_w = {counter_two_compare_b_i, counter_one_compare_b_i};

	for (genvar c = 0; c < CH_N; c++) begin : g_ch
		pwm_if u_bus ();

		assign u_bus.enable    = pwm_enable_i[c];
		assign u_bus.stop      = stop_mode_i;
		assign u_bus.hold      = stop_hold_i[c];
		assign u_bus.duty      = pwm_duty_i[c];
		assign u_bus.freq      = pwm_freq_i[c];
		assign u_bus.stop_duty = stop_duty_i[c];
		assign u_bus.stop_freq = stop_freq_i[c];
		assign wave_w[c]       = u_bus.wave;
		assign armed_w[c]      = u_bus.armed;

		pwm_gen #(
			.CLK_RATE (CLK_RATE)
		) u_pwm (
			.clk_i  (clk_i),
			.rstn_i (rstn_i),
			.port   (u_bus.gen)
		);

		// compare runs in every counter mode, on each accumulator update
		assign hit_a_w[c] = acc_update_i[c] & (acc_w[c] == cmp_a_w[c]);
		assign hit_b_w[c] = acc_update_i[c] & (acc_w[c] == cmp_b_w[c]);
		assign hit_nxt[c] = hit_a_w[c] | hit_b_w[c];

		// compare a wins when both values are met in the same update
		wire after_b_w = hit_b_w[c] ?
		                 act_apply(match_action_i[c][1], match_r[c]) :
		                 match_r[c];
		assign match_nxt[c] = hit_a_w[c] ?
		                      act_apply(match_action_i[c][0], match_r[c]) :
		                      after_b_w;

		// the output flop takes the new match state in the same edge
		assign out_nxt[c] = out_pick(out_mode_i[c], discrete_i[c],
		                             wave_w[c], match_nxt[c],
		                             step_drive_i[c]);

		// ------------------------------------------------------------
		// checks
		// ------------------------------------------------------------
		normal_drive_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] == MODE_NORMAL |=> out_r[c] == $past(discrete_i[c]))
			else $error("normal output does not follow discrete bit");

		pwm_drive_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] == MODE_PWM |=> out_r[c] == $past(wave_w[c]))
			else $error("pwm output does not follow generator");

		step_drive_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] == MODE_STEP |=> out_r[c] == $past(step_drive_i[c]))
			else $error("stepper output does not follow drive");

		match_drive_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] == MODE_MATCH |=> out_r[c] == match_r[c])
			else $error("match output not from own counter");

		match_on_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_a_w[c] && match_action_i[c][0] == ACT_ON |=> match_r[c])
			else $error("match on action not applied");

		match_off_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_a_w[c] && match_action_i[c][0] == ACT_OFF |=> !match_r[c])
			else $error("match off action not applied");

		match_toggle_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_b_w[c] && !hit_a_w[c] &&
			match_action_i[c][1] == ACT_TOGGLE
			|=> match_r[c] != $past(match_r[c]))
			else $error("toggle not applied one cycle after equality");

		compare_hit_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			acc_update_i[c] &&
			(acc_w[c] == cmp_a_w[c] || acc_w[c] == cmp_b_w[c])
			|=> match_hit_o[c])
			else $error("compare equality missed");

		match_quiet_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			!acc_update_i[c] |=> $stable(match_r[c]) && !match_hit_o[c])
			else $error("match state moved without update");

		// ------------------------------------------------------------
		// action, source and arming checks
		// ------------------------------------------------------------
		invalid_mode_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			!(out_mode_i[c] inside {MODE_NORMAL, MODE_PWM, MODE_MATCH,
			                        MODE_STEP}) |=> !out_r[c])
			else $error("invalid mode does not drive low");

		second_on_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_b_w[c] && !hit_a_w[c] &&
			match_action_i[c][1] == ACT_ON |=> match_r[c])
			else $error("second compare on action not applied");

		second_off_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_b_w[c] && !hit_a_w[c] &&
			match_action_i[c][1] == ACT_OFF |=> !match_r[c])
			else $error("second compare off action not applied");

		second_none_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_b_w[c] && !hit_a_w[c] &&
			match_action_i[c][1] == ACT_NONE |=> $stable(match_r[c]))
			else $error("second compare changed state with no action");

		first_toggle_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_a_w[c] && match_action_i[c][0] == ACT_TOGGLE
			|=> match_r[c] != $past(match_r[c]))
			else $error("first compare toggle not applied");

		first_none_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_a_w[c] && match_action_i[c][0] == ACT_NONE
			|=> $stable(match_r[c]))
			else $error("first compare changed state with no action");

		second_hit_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			hit_b_w[c] |=> match_hit_o[c])
			else $error("second compare equality missed");

		compare_miss_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			acc_update_i[c] && acc_w[c] != cmp_a_w[c] &&
			acc_w[c] != cmp_b_w[c]
			|=> !match_hit_o[c] && $stable(match_r[c]))
			else $error("hit reported without equality");

		compare_any_mode_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] != MODE_MATCH && hit_a_w[c] &&
			match_action_i[c][0] == ACT_ON |=> match_state_o[c])
			else $error("compare stopped outside match mode");

		hit_cause_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			match_hit_o[c] |-> $past(acc_update_i[c]))
			else $error("hit pulse without accumulator update");

		match_out_on_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] == MODE_MATCH && hit_a_w[c] &&
			match_action_i[c][0] == ACT_ON |=> out_r[c])
			else $error("match output not turned on");

		match_out_off_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			out_mode_i[c] == MODE_MATCH && hit_b_w[c] && !hit_a_w[c] &&
			match_action_i[c][1] == ACT_OFF |=> !out_r[c])
			else $error("match output not turned off");

		pwm_off_low_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			!pwm_enable_i[c] ##1 out_mode_i[c] == MODE_PWM |=> !out_r[c])
			else $error("disabled pwm channel drives high");

		pwm_unarmed_low_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			!pwm_ready_o[c] ##1 out_mode_i[c] == MODE_PWM |=> !out_r[c])
			else $error("unarmed pwm channel drives high");

		ready_set_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			pwm_duty_i[c] != VALUE_ZERO && pwm_freq_i[c] != VALUE_ZERO
			|=> pwm_ready_o[c])
			else $error("pwm not armed by non-zero parameters");

		ready_wait_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			!pwm_ready_o[c] &&
			(pwm_duty_i[c] == VALUE_ZERO || pwm_freq_i[c] == VALUE_ZERO)
			|=> !pwm_ready_o[c])
			else $error("pwm armed with a zero parameter");

		ready_keep_a: assert property (
			@(posedge clk_i) disable iff (!rstn_i)
			pwm_ready_o[c] |=> pwm_ready_o[c])
			else $error("pwm arming lost");
	end

	// ----------------------------------------------------------------
	// state and output flops
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			match_r <= '0;
			hit_r   <= '0;
			out_r   <= {CH_N{OUT_RST}};
		end else begin
			match_r <= match_nxt;
			hit_r   <= hit_nxt;
			out_r   <= out_nxt;
		end
	end

	assign fast_output_a_o = out_r[0];
	assign fast_output_b_o = out_r[1];
	assign match_state_o   = match_r;
	assign match_hit_o     = hit_r;
	assign pwm_ready_o     = armed_w;

	reset_low_a: assert property (
		@(posedge clk_i)
		!rstn_i |=> out_r == '0 && match_r == '0 && hit_r == '0 &&
		            pwm_ready_o == '0)
		else $error("outputs not cleared by reset");

endmodule : fast_out_top

`default_nettype wire

// ==== shared/fast_out_pkg.sv ====
// constants and types shared by the fast output block
// Functional notes
// - compare each counter accumulator with both its compare values, every mode
// - on equality turn the output on, off or toggle it as configured
// - two fast outputs, each set to normal, pwm, counter match or stepper
// - normal mode drives the output from its discrete output bit
// - pwm mode drives the output; channels enabled and set independently
// - new duty and frequency values take effect while running, no restart
// - duty is 0 to 32000, proportional to the high share of the period
// - duty 0 holds the output low, duty 32000 holds it high
// - frequency is a 32-bit value in hertz; period is its reciprocal
// - output stays low until both frequency and duty are loaded non-zero
// - in stop mode hold the last state or run on stop values
// - stop period or stop duty of zero keeps the output low in stop
// - match mode: output a from counter one, output b from counter two
`default_nettype none

package fast_out_pkg;

	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam logic [31:0] CLK_HZ        = 32'(1_000_000_000 / CLK_PERIOD_NS);
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned CH_N          = 2;
	localparam logic [31:0] DUTY_FULL     = 32'h0000_7d00;
	localparam logic [31:0] VALUE_ZERO    = 32'h0000_0000;
	localparam logic        OUT_RST       = 1'b0;

	// output modes, one-hot
	typedef enum logic [3:0] {
		MODE_NORMAL = 4'h1,
		MODE_PWM    = 4'h2,
		MODE_MATCH  = 4'h4,
		MODE_STEP   = 4'h8
	} mode_t;

	// action taken when a compare value is met
	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_ON     = 2'h1,
		ACT_OFF    = 2'h2,
		ACT_TOGGLE = 2'h3
	} act_t;

endpackage : fast_out_pkg

`default_nettype wire

// ==== shared/pwm_if.sv ====
// carrier between the output selector and one pwm generator
`default_nettype none

interface pwm_if;
	logic        enable;
	logic        stop;
	logic        hold;
	logic [31:0] duty;
	logic [31:0] freq;
	logic [31:0] stop_duty;
	logic [31:0] stop_freq;
	logic        wave;
	logic        armed;

	modport ctl (
		output enable, stop, hold, duty, freq, stop_duty, stop_freq,
		input  wave, armed
	);
	modport gen (
		input  enable, stop, hold, duty, freq, stop_duty, stop_freq,
		output wave, armed
	);
endinterface : pwm_if

`default_nettype wire

// ==== core/pwm_gen.sv ====
// one pwm channel: phase accumulator period, duty compare, stop handling
`default_nettype none

module pwm_gen #(
	parameter logic [31:0] CLK_RATE = fast_out_pkg::CLK_HZ
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	pwm_if.gen        port
);
	import fast_out_pkg::*;

	logic [31:0] acc_r;
	logic [31:0] acc_nxt;
	logic [31:0] duty_r;
	logic [31:0] duty_nxt;
	logic [31:0] freq_r;
	logic [31:0] freq_nxt;
	logic        armed_r;
	logic        armed_nxt;
	logic        wave_r;
	logic        wave_nxt;

	// ----------------------------------------------------------------
	// period and duty arithmetic
	// ----------------------------------------------------------------
	wire         live_w  = port.enable & armed_r;
	wire         hold_w  = port.stop & port.hold;
	wire         szero_w = port.stop & ~port.hold &
	                       (port.stop_duty == VALUE_ZERO |
	                        port.stop_freq == VALUE_ZERO);
	wire  [31:0] sduty_w = port.stop ? port.stop_duty : port.duty;
	wire  [31:0] sfreq_w = port.stop ? port.stop_freq : port.freq;
	// a step at or above the clock rate could not wrap in one subtraction
	wire  [31:0] step_w  = (freq_r >= CLK_RATE) ? CLK_RATE - 32'h1 : freq_r;
	wire  [32:0] sum_w   = {1'b0, acc_r} + {1'b0, step_w};
	wire         wrap_w  = sum_w >= {1'b0, CLK_RATE};
	wire  [32:0] left_w  = sum_w - {1'b0, CLK_RATE};
	wire         load_w  = ~live_w | (wrap_w & ~hold_w);
	wire  [63:0] lhs_w   = 64'(acc_r) * 64'(DUTY_FULL);
	wire  [63:0] rhs_w   = 64'(duty_r) * 64'(CLK_RATE);
	wire         high_w  = lhs_w < rhs_w;

	assign acc_nxt   = ~live_w ? VALUE_ZERO :
	                   hold_w  ? acc_r :
	                   wrap_w  ? left_w[31:0] : sum_w[31:0];
	assign duty_nxt  = load_w ? sduty_w : duty_r;
	assign freq_nxt  = load_w ? sfreq_w : freq_r;
	assign armed_nxt = armed_r | (port.duty != VALUE_ZERO &
	                              port.freq != VALUE_ZERO);
	assign wave_nxt  = ~live_w ? OUT_RST :
	                   hold_w  ? wave_r : (~szero_w & high_w);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			acc_r   <= VALUE_ZERO;
			duty_r  <= VALUE_ZERO;
			freq_r  <= VALUE_ZERO;
			armed_r <= 1'b0;
			wave_r  <= OUT_RST;
		end else begin
			acc_r   <= acc_nxt;
			duty_r  <= duty_nxt;
			freq_r  <= freq_nxt;
			armed_r <= armed_nxt;
			wave_r  <= wave_nxt;
		end
	end

	assign port.wave  = wave_r;
	assign port.armed = armed_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	unarmed_low_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		!armed_r |=> !wave_r)
		else $error("pwm high before parameters loaded");

	duty_zero_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		duty_r == VALUE_ZERO && !port.stop |=> !wave_r)
		else $error("pwm high with zero duty");

	duty_full_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		live_w && !port.stop && duty_r == DUTY_FULL |=> wave_r)
		else $error("pwm low with full duty");

	stop_zero_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		live_w && szero_w |=> !wave_r)
		else $error("pwm high in stop with zero stop value");

	stop_hold_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		live_w && hold_w |=> $stable(wave_r) && $stable(acc_r))
		else $error("pwm moved while holding in stop");

	boundary_load_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		live_w && wrap_w && !hold_w |=> duty_r == $past(sduty_w))
		else $error("new duty not taken at period boundary");

	phase_bound_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		acc_r < CLK_RATE)
		else $error("phase accumulator out of range");

endmodule : pwm_gen

`default_nettype wire

// ==== verif/fast_out_load.sv ====
// load model on the two fast outputs: counts high cycles and rising edges
`default_nettype none

module fast_out_load (
	input  wire logic             clk_i,
	input  wire logic             clr_i,
	input  wire logic [1:0]       line_i,
	output logic      [1:0][15:0] high_cnt_o,
	output logic      [1:0][15:0] rise_cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] line_r;

	always_ff @(posedge clk_i) begin
		line_r <= line_i;
		for (int i = 0; i < 2; i++) begin
			if (clr_i) begin
				high_cnt_o[i] <= 16'h0000;
				rise_cnt_o[i] <= 16'h0000;
			end else begin
				high_cnt_o[i] <= high_cnt_o[i] + 16'(line_i[i]);
				rise_cnt_o[i] <= rise_cnt_o[i] + 16'(line_i[i] & ~line_r[i]);
			end
		end
	end
endmodule : fast_out_load

`default_nettype wire

// ==== verif/high_speed_output_pwm_match_tb.sv ====
// self-checking bench for the two fast outputs
`default_nettype none

module high_speed_output_pwm_match_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fast_out_pkg::*;

	// pwm phase wraps at 1000, so 125 Hz gives an 8 cycle period
	localparam logic [31:0] RATE = 32'h0000_03e8;

	logic             clk_i = 1'b0;
	logic             rstn_i = 1'b0;
	mode_t [1:0]      mode;
	logic [1:0]       disc, step, en, upd, hold, st, ht, rdy;
	logic [1:0][31:0] duty, freq, sduty, sfreq;
	logic             stop, clr, oa, ob;
	logic [31:0]      acc1, acc2, c1a, c1b, c2a, c2b;
	act_t [1:0][1:0]  act;
	logic [1:0][15:0] hcnt, rcnt;
	int               error_cnt = 0;
	int               cmp_count = 0;
	int               cyc = 0;

	fast_out_top #(.CLK_RATE(RATE)) fast_out_top_inst (
		.clk_i(clk_i), .rstn_i(rstn_i), .out_mode_i(mode),
		.discrete_i(disc), .step_drive_i(step), .pwm_enable_i(en),
		.pwm_duty_i(duty), .pwm_freq_i(freq), .stop_mode_i(stop),
		.stop_hold_i(hold), .stop_duty_i(sduty), .stop_freq_i(sfreq),
		.counter_one_accumulator_i(acc1), .counter_two_accumulator_i(acc2),
		.acc_update_i(upd), .counter_one_compare_a_i(c1a),
		.counter_one_compare_b_i(c1b), .counter_two_compare_a_i(c2a),
		.counter_two_compare_b_i(c2b), .match_action_i(act),
		.fast_output_a_o(oa), .fast_output_b_o(ob), .match_state_o(st),
		.match_hit_o(ht), .pwm_ready_o(rdy)
	);

	fast_out_load fast_out_load_inst (
		.clk_i(clk_i), .clr_i(clr), .line_i({ob, oa}),
		.high_cnt_o(hcnt), .rise_cnt_o(rcnt)
	);

	always #25 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic final_report();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// settle, then count 40 cycles: highs and rises on both lines
	task automatic measure(input logic [15:0] ea, eb, ra, rb);
		repeat (16) @(negedge clk_i);
		clr = 1'b1;
		@(negedge clk_i);
		clr = 1'b0;
		repeat (40) @(negedge clk_i);
		chk("high_a", 32'(ea), 32'(hcnt[0]));
		chk("high_b", 32'(eb), 32'(hcnt[1]));
		chk("rise_a", 32'(ra), 32'(rcnt[0]));
		chk("rise_b", 32'(rb), 32'(rcnt[1]));
	endtask : measure

	// one accumulator value per cycle, strobed when u is set
	task automatic hit(input int c, input logic [31:0] v,
			input logic u, eh, es);
		if (c == 0) begin
			acc1 = v;
		end else begin
			acc2 = v;
		end
		upd = u ? 2'(1 << c) : 2'b00;
		@(negedge clk_i);
		chk("hit", 32'(eh), 32'(ht[c]));
		chk("state", 32'(es), 32'(st[c]));
		chk("out", 32'(es), 32'(c == 0 ? oa : ob));
	endtask : hit

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		mode = {MODE_NORMAL, MODE_NORMAL};
		disc = 2'b00;
		step = 2'b00;
		en = 2'b00;
		upd = 2'b00;
		hold = 2'b00;
		duty = '0;
		freq = '0;
		sduty = '0;
		sfreq = '0;
		stop = 1'b0;
		clr = 1'b0;
		acc1 = '0;
		acc2 = '0;
		c1a = 32'h0000_000a;
		c1b = 32'h0000_0014;
		c2a = 32'h0000_0007;
		c2b = 32'h0000_0009;
		act = {ACT_ON, ACT_TOGGLE, ACT_OFF, ACT_ON};
		repeat (4) @(negedge clk_i);
		rstn_i = 1'b1;
		disc = 2'b01;
		@(negedge clk_i);
		chk("out_a", 1'b1, oa);
		chk("out_b", 1'b0, ob);
		mode = {MODE_STEP, MODE_NORMAL};
		step = 2'b10;
		@(negedge clk_i);
		chk("out_b", 1'b1, ob);
		mode = {MODE_STEP, mode_t'(4'h3)};
		@(negedge clk_i);
		chk("out_a", 1'b0, oa);
		mode = {MODE_PWM, MODE_PWM};
		en = 2'b11;
		freq = {32'd250, 32'd125};
		measure(16'd0, 16'd0, 16'd0, 16'd0);
		chk("ready", 2'b00, rdy);
		duty = {32'd16000, 32'd8000};
		measure(16'd10, 16'd20, 16'd5, 16'd10);
		chk("ready", 2'b11, rdy);
		duty[0] = 32'd16000;
		measure(16'd20, 16'd20, 16'd5, 16'd10);
		duty[0] = DUTY_FULL;
		measure(16'd40, 16'd20, 16'd0, 16'd10);
		duty[0] = VALUE_ZERO;
		measure(16'd0, 16'd20, 16'd0, 16'd10);
		duty[0] = 32'd16000;
		en = 2'b10;
		measure(16'd0, 16'd20, 16'd0, 16'd10);
		en = 2'b11;
		repeat (21) @(negedge clk_i);
		stop = 1'b1;
		hold = 2'b11;
		repeat (3) @(negedge clk_i);
		// channel a freezes in its low half, channel b in its high half
		chk("held_a", 32'h0000_0000, 32'(oa));
		chk("held_b", 32'h0000_0001, 32'(ob));
		measure(16'd0, 16'd40, 16'd0, 16'd0);
		hold = 2'b00;
		sduty = {32'd16000, 32'd8000};
		sfreq = {32'd0, 32'd125};
		measure(16'd10, 16'd0, 16'd5, 16'd0);
		stop = 1'b0;
		mode = {MODE_MATCH, MODE_MATCH};
		@(negedge clk_i);
		hit(0, 32'd10, 1'b1, 1'b1, 1'b1);
		hit(0, 32'd20, 1'b1, 1'b1, 1'b0);
		hit(0, 32'd15, 1'b1, 1'b0, 1'b0);
		act[0][1] = ACT_TOGGLE;
		hit(0, 32'd20, 1'b1, 1'b1, 1'b1);
		hit(0, 32'd20, 1'b1, 1'b1, 1'b0);
		act[0][0] = ACT_NONE;
		hit(0, 32'd10, 1'b1, 1'b1, 1'b0);
		act[0] = {ACT_OFF, ACT_ON};
		c1b = 32'h0000_000a;
		hit(0, 32'd10, 1'b1, 1'b1, 1'b1);
		hit(1, 32'd7, 1'b1, 1'b1, 1'b1);
		hit(1, 32'd7, 1'b1, 1'b1, 1'b0);
		hit(1, 32'd9, 1'b1, 1'b1, 1'b1);
		hit(1, 32'd7, 1'b0, 1'b0, 1'b1);
		mode[0] = MODE_NORMAL;
		hit(0, 32'd10, 1'b1, 1'b1, 1'b1);
		act[1][1] = ACT_NONE;
		hit(1, 32'd9, 1'b1, 1'b1, 1'b1);
		final_report();
	end
endmodule : high_speed_output_pwm_match_tb

`default_nettype wire
